/* inc/surface_cfg.svh */
// Register map, field positions, reset values and timing figures
// for the control-surface input logic. Definitions only.
`ifndef SURFACE_CFG_SVH
`define SURFACE_CFG_SVH

// ==========================================================
// Register byte offsets
`define OFF_CTRL 8'h00
`define OFF_BRIGHT 8'h04
`define OFF_LONGP 8'h08
`define OFF_CL12 8'h0c
`define OFF_GROUPCOL 8'h10
`define OFF_STRIP0 8'h14
`define OFF_STRIP1 8'h18
`define OFF_STATUS 8'h1c
`define OFF_GPIO0 8'h20
`define OFF_GAIN0 8'h40
`define OFF_LAST 8'h5c

// ==========================================================
// Control register fields
`define CTRL_SHIFT_ARM 0
`define CTRL_SHIFT_MUTE 1
`define CTRL_SHOW_GAIN 2
`define CTRL_SOLO_FOLLOWS 3
`define CTRL_SOFT_PICKUP 4
`define CTRL_BANK_DISABLE 5
`define CTRL_SEL_FOLLOWS 6
`define CTRL_REMOTE_ACTIVE 7
`define CTRL_RESET 8'h4c

// ==========================================================
// Brightness and long press, percent and milliseconds
`define BRIGHT_MIN 7'h05
`define BRIGHT_MAX 7'h64
`define BRIGHT_STEP 7'h05
`define BRIGHT_RESET 7'h64
`define LONGP_MIN_MS 10'h12c
`define LONGP_MAX_MS 10'h3e8
`define LONGP_STEP_MS 10'h005
`define LONGP_RESET_MS 10'h1f4
`define CLK_HZ 100000000
`define MS_PER_S 1000

// ==========================================================
// 12-fader controller fields and resets
`define CL12_LEVEL_RESET 2'h1
`define CL12_METER_BIT 2
`define CL12_ROUTE_BIT 3

// ==========================================================
// Colours and GPIO
`define GROUPCOL_RESET 16'h3210
`define STRIP_RESET 32'h0000_0000
`define GPIO_DIR_BIT 0
`define GPIO_LOW_BIT 1
`define GPIO_FUNC_LSB 8
`define FUNC_NONE 6'h00
`define FUNC_RECORD 6'h01
`define FUNC_PLAY 6'h02
`define FUNC_STOP 6'h03

`endif

/* inc/surface_pkg.sv */
// Types shared by the control-surface logic.
// Assumes surface_cfg.svh supplies the numeric constants.
package surface_pkg;

  // Display colours, in menu order
  typedef enum logic [3:0] {
    col_yellow, col_orange, col_light_blue, col_light_green, col_green,
    col_light_brown, col_brown, col_violet, col_pink
  } color_t;

  // Long-press timer states
  typedef enum logic [1:0] {
    pt_idle, pt_timing, pt_long
  } press_state_t;

  // GPIO port configuration
  typedef struct packed {
    logic [5:0] func;
    logic active_low;
    logic is_output;
  } gpio_cfg_t;

endpackage

/* logic/press_timer.sv */
// Classifies one held button as a short or a long press.
// Assumes held is already in the pclk domain.
`timescale 1ns/1ns
`default_nettype none
`include "surface_cfg.svh"
module press_timer
  import surface_pkg::*;
#(
  parameter int CYC_PER_MS = `CLK_HZ / `MS_PER_S
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Button and threshold
  input wire logic held,
  input wire logic [9:0] thresh_ms,
  // Classified presses
  output logic long_p,
  output logic short_p
);

  press_state_t state_q;
  logic [31:0] pre_q;
  logic [9:0] ms_q;
  logic tick;

  assign tick = (pre_q == 32'(CYC_PER_MS - 1));

  // ==========================================================
  // Press classification
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= pt_idle;
      pre_q <= 32'h0;
      ms_q <= 10'h0;
      long_p <= 1'b0;
      short_p <= 1'b0;
    end else begin
      long_p <= 1'b0;
      short_p <= 1'b0;
      case (state_q)
        pt_idle: begin
          pre_q <= 32'h0;
          ms_q <= 10'h0;
          if (held) state_q <= pt_timing;
        end
        pt_timing: begin
          if (!held) begin
            short_p <= 1'b1;
            state_q <= pt_idle;
          end else if (ms_q >= thresh_ms) begin
            long_p <= 1'b1;
            state_q <= pt_long;
          end else if (tick) begin
            pre_q <= 32'h0;
            ms_q <= ms_q + 10'h1;
          end else begin
            pre_q <= pre_q + 32'h1;
          end
        end
        default: begin
          if (!held) state_q <= pt_idle;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

/* logic/surface_input.sv */
// Control-surface input: buttons, soft pickup, settings, GPIO, APB slave.
// Assumes same-clock decoded events; GPIO pins are synchronised here.
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "surface_cfg.svh"
module surface_input
  import surface_pkg::*;
#(
  parameter int NCH = 8,
  parameter int NGPIO = 8,
  parameter int CYC_PER_MS = `CLK_HZ / `MS_PER_S
) (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Surface state
  input wire logic surf_third_party,
  input wire logic surf_cl12,
  input wire logic controller_connected,
  input wire logic transport_stopped,
  // Button events and held levels
  input wire logic [3:0] btn_ch,
  input wire logic press_rec,
  input wire logic press_mute,
  input wire logic press_select,
  input wire logic press_pfl,
  input wire logic press_stop,
  input wire logic shift_held,
  input wire logic com1_held,
  input wire logic com2_held,
  input wire logic timed_held,
  // Fader events
  input wire logic fader_valid,
  input wire logic [2:0] fader_ch,
  input wire logic [7:0] fader_pos,
  input wire logic fader_from_ctrl,
  input wire logic fader_motorized,
  // Actions
  output logic [3:0] act_ch,
  output logic arm_pulse,
  output logic mute_pulse,
  output logic select_pulse,
  output logic pfl_pulse,
  output logic slate_on,
  output logic edit_current,
  output logic long_press,
  output logic short_press,
  output logic [NCH-1:0][7:0] gain,
  // Settings toward the controllers
  output logic show_gain,
  output logic bank_disable,
  output logic [6:0] led_bright,
  output logic [6:0] lcd_bright,
  output logic [6:0] cl12_led_bright,
  output logic [9:0] long_ms,
  output logic [1:0] cl12_level_mode,
  output logic cl12_meter_out,
  output logic cl12_route_out,
  output logic [3:0][3:0] group_color,
  output logic [15:0][3:0] strip_color,
  // GPIO
  input wire logic [NGPIO-1:0] gpio_i,
  output logic [NGPIO-1:0] gpio_o,
  output logic [NGPIO-1:0] gpio_oe,
  output logic [NGPIO-1:0] gpio_trig,
  input wire logic [63:0] func_active
);

  // ==========================================================
  // Helpers
  // Snaps a setting onto its legal grid instead of refusing it
  function automatic logic [9:0] snap(input logic [9:0] v, input logic [9:0] lo,
                                      input logic [9:0] hi, input logic [9:0] step);
    logic [9:0] r;
    r = v;
    if (r < lo) r = lo;
    if (r > hi) r = hi;
    snap = r - (r % step);
  endfunction

  function automatic logic [6:0] snap_bright(input logic [6:0] v);
    logic [9:0] r;
    r = snap({3'h0, v}, {3'h0, `BRIGHT_MIN}, {3'h0, `BRIGHT_MAX}, {3'h0, `BRIGHT_STEP});
    snap_bright = r[6:0];
  endfunction

  function automatic gpio_cfg_t gpio_default(input int i);
    gpio_cfg_t c;
    c = '0;
    case (i)
      0, 5: c.func = `FUNC_RECORD;
      1, 6: c.func = `FUNC_PLAY;
      2, 7: c.func = `FUNC_STOP;
      default: c.func = `FUNC_NONE;
    endcase
    gpio_default = c;
  endfunction

  // ==========================================================
  // APB decode
  logic [7:0] ctrl_q;
  logic [NGPIO-1:0] gpio_act_prev_q;
  gpio_cfg_t [NGPIO-1:0] gpio_cfg_q;
  logic [1:0][NCH-1:0] picked_q, seen_q, above_q;
  logic access, wr_en, rd_phase;
  logic [31:0] rdata_d;
  logic err_d;

  // One wait state: data is prepared, then pready is raised
  assign access = psel && penable;
  assign rd_phase = access && !pready;
  assign wr_en = access && pready && pwrite;

  always_comb begin
    rdata_d = 32'h0;
    err_d = 1'b0;
    if (paddr[1:0] != 2'h0 || paddr > `OFF_LAST) begin
      err_d = 1'b1;
    end else if (paddr == `OFF_CTRL) begin
      rdata_d = {24'h0, ctrl_q};
    end else if (paddr == `OFF_BRIGHT) begin
      rdata_d = {9'h0, cl12_led_bright, 1'b0, lcd_bright, 1'b0, led_bright};
    end else if (paddr == `OFF_LONGP) begin
      rdata_d = {22'h0, long_ms};
    end else if (paddr == `OFF_CL12) begin
      rdata_d = {28'h0, cl12_route_out, cl12_meter_out, cl12_level_mode};
    end else if (paddr == `OFF_GROUPCOL) begin
      rdata_d = {16'h0, group_color};
    end else if (paddr == `OFF_STRIP0) begin
      rdata_d = strip_color[7:0];
    end else if (paddr == `OFF_STRIP1) begin
      rdata_d = strip_color[15:8];
    end else if (paddr == `OFF_STATUS) begin
      rdata_d = {8'h0, picked_q[1], picked_q[0], 6'h0, edit_current, slate_on};
    end else if (paddr < `OFF_GAIN0) begin
      rdata_d = {18'h0, gpio_cfg_q[paddr[4:2]].func, 6'h0,
                 gpio_cfg_q[paddr[4:2]].active_low, gpio_cfg_q[paddr[4:2]].is_output};
    end else begin
      rdata_d = {24'h0, gain[paddr[4:2]]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= rd_phase;
      prdata <= rd_phase ? rdata_d : 32'h0;
      pslverr <= rd_phase && err_d;
    end
  end

  // ==========================================================
  // Settings registers
  logic wr_ok;
  assign wr_ok = wr_en && !pslverr;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `CTRL_RESET;
      led_bright <= `BRIGHT_RESET;
      lcd_bright <= `BRIGHT_RESET;
      cl12_led_bright <= `BRIGHT_RESET;
      long_ms <= `LONGP_RESET_MS;
      cl12_level_mode <= `CL12_LEVEL_RESET;
      cl12_meter_out <= 1'b0;
      cl12_route_out <= 1'b0;
      group_color <= `GROUPCOL_RESET;
      strip_color <= {`STRIP_RESET, `STRIP_RESET};
    end else if (wr_ok) begin
      if (paddr == `OFF_CTRL) begin
        ctrl_q <= pwdata[7:0];
      end else if (paddr == `OFF_BRIGHT) begin
        led_bright <= snap_bright(pwdata[6:0]);
        lcd_bright <= snap_bright(pwdata[14:8]);
        cl12_led_bright <= snap_bright(pwdata[22:16]);
      end else if (paddr == `OFF_LONGP) begin
        long_ms <= snap(pwdata[9:0], `LONGP_MIN_MS, `LONGP_MAX_MS, `LONGP_STEP_MS);
      end else if (paddr == `OFF_CL12) begin
        // Code 3 is not a mode; treat it as disabled
        cl12_level_mode <= (pwdata[1:0] == 2'h3) ? 2'h2 : pwdata[1:0];
        cl12_meter_out <= pwdata[`CL12_METER_BIT];
        cl12_route_out <= pwdata[`CL12_ROUTE_BIT];
      end else if (paddr == `OFF_GROUPCOL) begin
        group_color <= pwdata[15:0];
      end else if (paddr == `OFF_STRIP0) begin
        strip_color[7:0] <= pwdata;
      end else if (paddr == `OFF_STRIP1) begin
        strip_color[15:8] <= pwdata;
      end
    end
  end
  assign show_gain = ctrl_q[`CTRL_SHOW_GAIN];
  assign bank_disable = ctrl_q[`CTRL_BANK_DISABLE];

  // ==========================================================
  // GPIO configuration and pins
  logic [NGPIO-1:0] gpio_s1_q, gpio_s2_q, gpio_act;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NGPIO; i++) gpio_cfg_q[i] <= gpio_default(i);
    end else if (wr_ok && paddr >= `OFF_GPIO0 && paddr < `OFF_GAIN0) begin
      gpio_cfg_q[paddr[4:2]].is_output <= pwdata[`GPIO_DIR_BIT];
      gpio_cfg_q[paddr[4:2]].active_low <= pwdata[`GPIO_LOW_BIT];
      gpio_cfg_q[paddr[4:2]].func <= pwdata[`GPIO_FUNC_LSB +: 6];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gpio_s1_q <= '0;
      gpio_s2_q <= '0;
    end else begin
      gpio_s1_q <= gpio_i;
      gpio_s2_q <= gpio_s1_q;
    end
  end

  always_comb begin
    for (int i = 0; i < NGPIO; i++) begin
      gpio_act[i] = (gpio_s2_q[i] ^ gpio_cfg_q[i].active_low) && !gpio_cfg_q[i].is_output
                    && gpio_cfg_q[i].func != `FUNC_NONE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gpio_o <= '0;
      gpio_oe <= '0;
      gpio_trig <= '0;
      gpio_act_prev_q <= '0;
    end else begin
      gpio_act_prev_q <= gpio_act;
      gpio_trig <= gpio_act & ~gpio_act_prev_q;
      for (int i = 0; i < NGPIO; i++) begin
        gpio_oe[i] <= gpio_cfg_q[i].is_output;
        // An unmapped output rests at its inactive level
        gpio_o[i] <= ((gpio_cfg_q[i].func != `FUNC_NONE) && func_active[gpio_cfg_q[i].func])
                     ^ gpio_cfg_q[i].active_low;
      end
    end
  end

  // ==========================================================
  // Button qualification
  logic com_both_prev_q, stop_ok;
  assign stop_ok = press_stop && transport_stopped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_ch <= 4'h0;
      arm_pulse <= 1'b0;
      mute_pulse <= 1'b0;
      select_pulse <= 1'b0;
      pfl_pulse <= 1'b0;
    end else begin
      act_ch <= btn_ch;
      arm_pulse <= press_rec && (!surf_third_party || !ctrl_q[`CTRL_SHIFT_ARM] || shift_held);
      mute_pulse <= press_mute && (!surf_third_party || !ctrl_q[`CTRL_SHIFT_MUTE] || shift_held);
      select_pulse <= press_select || (press_pfl && surf_cl12 && ctrl_q[`CTRL_SEL_FOLLOWS]);
      pfl_pulse <= press_pfl || (press_select && ctrl_q[`CTRL_SOLO_FOLLOWS]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slate_on <= 1'b0;
      com_both_prev_q <= 1'b0;
    end else begin
      com_both_prev_q <= com1_held && com2_held;
      if (com1_held && com2_held && !com_both_prev_q && surf_cl12) slate_on <= !slate_on;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) edit_current <= 1'b0;
    else if (stop_ok) edit_current <= !edit_current;
  end

  press_timer #(.CYC_PER_MS(CYC_PER_MS)) u_press_timer (
    .pclk(pclk),
    .presetn(presetn),
    .held(timed_held),
    .thresh_ms(long_ms),
    .long_p(long_press),
    .short_p(short_press)
  );

  // ==========================================================
  // Gain and soft pickup
  // Index 0 is the front panel, index 1 the external controller.
  logic src, direct, ignore, reached, remote_wr, above_now;
  assign src = fader_from_ctrl;
  assign remote_wr = wr_ok && paddr >= `OFF_GAIN0;
  assign above_now = fader_pos > gain[fader_ch];
  // Motorized faders already sit on the stored gain
  assign direct = fader_motorized || (src && !ctrl_q[`CTRL_SOFT_PICKUP])
                  || (src && ctrl_q[`CTRL_REMOTE_ACTIVE]);
  assign ignore = !src && !ctrl_q[`CTRL_SOFT_PICKUP] && controller_connected;
  assign reached = (fader_pos == gain[fader_ch])
                   || (seen_q[src][fader_ch] && above_q[src][fader_ch] != above_now);

  // Software restores saved gains after power-up; controls must re-catch them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gain <= '0;
      picked_q <= '0;
      seen_q <= '0;
      above_q <= '0;
    end else if (remote_wr) begin
      gain[paddr[4:2]] <= pwdata[7:0];
      for (int s = 0; s < 2; s++) begin
        picked_q[s][paddr[4:2]] <= 1'b0;
        seen_q[s][paddr[4:2]] <= 1'b0;
      end
    end else if (fader_valid && !ignore) begin
      seen_q[src][fader_ch] <= 1'b1;
      above_q[src][fader_ch] <= above_now;
      if (direct || picked_q[src][fader_ch] || reached) begin
        gain[fader_ch] <= fader_pos;
        picked_q[src][fader_ch] <= 1'b1;
        picked_q[!src][fader_ch] <= 1'b0;
        seen_q[!src][fader_ch] <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

/* tb/surface_input_sva.sv */
// Checker for the control-surface input block.
// Assumes it is bound to surface_input and sees only that module's ports.
`timescale 1ns/1ns
`default_nettype none
module surface_input_sva (
  // Clock, reset, APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Surface events
  input wire logic surf_cl12,
  input wire logic transport_stopped,
  input wire logic press_rec,
  input wire logic press_mute,
  input wire logic press_select,
  input wire logic press_stop,
  input wire logic com1_held,
  input wire logic com2_held,
  input wire logic timed_held,
  // Results
  input wire logic arm_pulse,
  input wire logic mute_pulse,
  input wire logic select_pulse,
  input wire logic slate_on,
  input wire logic edit_current,
  input wire logic long_press,
  input wire logic short_press,
  input wire logic [6:0] led_bright,
  input wire logic [9:0] long_ms
);
  // ==========
  // Properties
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_APB_WAIT: assert property (psel && penable && !pready |=> pready)
    else $error("No ready after one wait state");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("Ready longer than one cycle");
  AST_ERR_READY: assert property (pslverr |-> pready)
    else $error("Error flag without ready");
  AST_ARM: assert property (arm_pulse |-> $past(press_rec))
    else $error("Arm without record press");
  AST_MUTE: assert property (mute_pulse |-> $past(press_mute))
    else $error("Mute without mute press");
  AST_SEL: assert property (press_select |=> select_pulse)
    else $error("Select not passed on");
  AST_STOP_IDLE: assert property (press_stop && transport_stopped |=> edit_current != $past(edit_current))
    else $error("Stop while stopped kept edit target");
  AST_STOP_RUN: assert property (press_stop && !transport_stopped |=> $stable(edit_current))
    else $error("Stop while running moved edit target");
  AST_SLATE: assert property (surf_cl12 && $rose(com1_held && com2_held) |=> slate_on != $past(slate_on))
    else $error("Talkback pair did not toggle slate");
  AST_LONG_MS: assert property (long_ms >= 10'h12c && long_ms <= 10'h3e8 && long_ms % 5 == 0)
    else $error("Long-press threshold off grid");
  AST_BRIGHT: assert property (led_bright >= 7'h05 && led_bright <= 7'h64 && led_bright % 5 == 0)
    else $error("Brightness off grid");
  AST_ONE_CLASS: assert property (short_press |-> !long_press && !$past(timed_held))
    else $error("Short press while held or with long");
  COV_SEL: cover property (press_select ##1 select_pulse);
  COV_STOP: cover property (press_stop && transport_stopped);
  COV_SLATE: cover property (surf_cl12 && com1_held && com2_held);
  COV_LONG: cover property (long_press);
endmodule

bind surface_input surface_input_sva surface_input_sva_i (.*);
`default_nettype wire

/* tb/surface_model.sv */
// Far-side model: a fader surface issuing button, hold and fader events.
// Assumes tb_top calls its tasks; lines change by NBA after pclk edges.
`timescale 1ns/1ns
`default_nettype none
module surface_model (
  // Clock
  input wire logic pclk,
  // Events toward the block
  output logic [3:0] btn_ch,
  output logic [4:0] press,
  output logic shift_held,
  output logic com1_held,
  output logic com2_held,
  output logic timed_held,
  output logic fader_valid,
  output logic [2:0] fader_ch,
  output logic [7:0] fader_pos,
  output logic fader_from_ctrl,
  output logic fader_motorized
);
  initial begin
    {btn_ch, press, shift_held, com1_held, com2_held, timed_held} = '0;
    {fader_valid, fader_ch, fader_pos, fader_from_ctrl, fader_motorized} = '0;
  end
  // ==========
  // Press order: rec, mute, select, pre_fade_listen, stop
  task automatic tap(input int k, input logic [3:0] ch, input logic sh);
    @(posedge pclk);
    press <= 5'(1 << k);
    btn_ch <= ch;
    shift_held <= sh;
    @(posedge pclk);
    press <= '0;
    btn_ch <= ~ch;
    shift_held <= 1'b0;
  endtask
  task automatic talk();
    @(posedge pclk);
    com1_held <= 1'b1;
    @(posedge pclk);
    com2_held <= 1'b1;
    @(posedge pclk);
    {com1_held, com2_held} <= 2'b00;
  endtask
  task automatic hold(input int n);
    @(posedge pclk);
    timed_held <= 1'b1;
    repeat (n) @(posedge pclk);
    timed_held <= 1'b0;
  endtask
  // Position scrambled once taken, so stale values never match
  task automatic move(input logic [7:0] pos, input logic ctl, input logic mot);
    @(posedge pclk);
    fader_valid <= 1'b1;
    fader_pos <= pos;
    fader_from_ctrl <= ctl;
    fader_motorized <= mot;
    @(posedge pclk);
    fader_valid <= 1'b0;
    fader_pos <= ~pos;
  endtask
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench for surface_input beside its surface model.
// Assumes the package and design are compiled first.
`timescale 1ns/1ns
`default_nettype none
`include "surface_cfg.svh"
module tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, third, cl12, conn, stopped;
  logic [7:0] paddr, gpio_i, gpio_o, gpio_oe, gpio_trig, t;
  logic [31:0] pwdata, prdata;
  logic [3:0] btn_ch, act_ch;
  logic [4:0] press;
  logic shift_held, com1_held, com2_held, timed_held, fader_valid, fader_from_ctrl, fader_motorized;
  logic [2:0] fader_ch;
  logic [7:0] fader_pos;
  logic arm_pulse, mute_pulse, select_pulse, pfl_pulse, slate_on, edit_current, long_press, short_press;
  logic [7:0][7:0] gain;
  logic show_gain, bank_disable;
  logic [6:0] led_bright, lcd_bright, cl12_led_bright, v, b;
  logic [9:0] long_ms, l, lm, obs;
  logic [63:0] func_active;
  logic [33:0] ent, rd_q[$];
  logic [9:0] act_q[$];
  logic [7:0] dflt[8] = '{8'h01, 8'h02, 8'h03, 8'h00, 8'h00, 8'h01, 8'h02, 8'h03};
  int err_total, compares, i;

  surface_input #(.CYC_PER_MS(10)) surface_input_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .surf_third_party(third),
    .surf_cl12(cl12), .controller_connected(conn), .transport_stopped(stopped), .btn_ch(btn_ch),
    .press_rec(press[0]), .press_mute(press[1]), .press_select(press[2]), .press_pfl(press[3]),
    .press_stop(press[4]), .shift_held(shift_held), .com1_held(com1_held), .com2_held(com2_held),
    .timed_held(timed_held), .fader_valid(fader_valid), .fader_ch(fader_ch), .fader_pos(fader_pos),
    .fader_from_ctrl(fader_from_ctrl), .fader_motorized(fader_motorized), .act_ch(act_ch),
    .arm_pulse(arm_pulse), .mute_pulse(mute_pulse), .select_pulse(select_pulse), .pfl_pulse(pfl_pulse),
    .slate_on(slate_on), .edit_current(edit_current), .long_press(long_press), .short_press(short_press),
    .gain(gain), .show_gain(show_gain), .bank_disable(bank_disable), .led_bright(led_bright),
    .lcd_bright(lcd_bright), .cl12_led_bright(cl12_led_bright), .long_ms(long_ms), .cl12_level_mode(),
    .cl12_meter_out(), .cl12_route_out(), .group_color(), .strip_color(), .gpio_i(gpio_i),
    .gpio_o(gpio_o), .gpio_oe(gpio_oe), .gpio_trig(gpio_trig), .func_active(func_active));
  surface_model surface_model_i (.*);

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // ==========
  // Checking and closing
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("Compares %0d errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  function automatic int fit(input int x, input int lo, input int hi);
    x = x < lo ? lo : (x > hi ? hi : x);
    return x - x % 5;
  endfunction
  // ==========
  // Bus and button drivers queue the expected result first; fad checks gain[0] itself
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] exp);
    int n;
    rd_q.push_back({w, exp});
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20 && pready !== 1'b1; n++) @(posedge pclk);
    if (n == 20) begin
      err_total++;
      complete_run();
    end
    {psel, penable} <= 2'b00;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
    @(negedge pclk);
  endtask
  task automatic ev(input int k, input logic [3:0] ch, input logic sh, input logic [9:0] exp);
    if (exp != 10'h0) act_q.push_back(exp);
    surface_model_i.tap(k, ch, sh);
    @(negedge pclk);
  endtask
  task automatic fad(input logic [7:0] p, input logic c, input logic m, input logic [7:0] e);
    surface_model_i.move(p, c, m);
    @(negedge pclk);
    check(34'(gain[0]), 34'(e));
  endtask
  // Each result takes the oldest note
  always @(negedge pclk) begin
    if (pready === 1'b1) begin
      ent = rd_q.size() > 0 ? rd_q.pop_front() : 34'h3_ffff_ffff;
      check({1'b0, pslverr, ent[33] ? 32'h0 : prdata}, {1'b0, ent[32:0] & {1'b1, {32{~ent[33]}}}});
    end
    obs = {arm_pulse, mute_pulse, select_pulse, pfl_pulse, long_press, short_press, act_ch};
    obs[3:0] = |obs[9:6] ? obs[3:0] : 4'h0;
    if (|obs[9:4]) check(34'(obs), 34'(act_q.size() > 0 ? act_q.pop_front() : 10'h0));
  end
  // ==========
  // Main sequence
  initial begin
    void'($urandom(20));
    {presetn, psel, penable, pwrite, paddr, pwdata, third, cl12, conn, stopped} = '0;
    {gpio_i, func_active} = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `OFF_CTRL, 32'h0, 33'h4c);
    apb(1'b0, `OFF_BRIGHT, 32'h0, 33'h64_6464);
    apb(1'b0, `OFF_LONGP, 32'h0, 33'h1f4);
    apb(1'b0, `OFF_CL12, 32'h0, 33'h1);
    apb(1'b0, `OFF_GROUPCOL, 32'h0, 33'h3210);
    apb(1'b0, `OFF_STRIP1, 32'h0, 33'h0);
    for (i = 0; i < 8; i++) apb(1'b0, `OFF_GPIO0 + 8'(4 * i), 32'h0, {17'h0, dflt[i], 8'h0});
    check(34'({show_gain, bank_disable}), 34'h2);
    apb(1'b0, 8'h60, 32'h0, {1'b1, 32'h0});
    apb(1'b1, 8'h02, 32'h0, {1'b1, 32'h0});
    apb(1'b0, `OFF_CTRL, 32'h0, 33'h4c);
    apb(1'b1, `OFF_CL12, 32'hf, 33'h0);
    apb(1'b0, `OFF_CL12, 32'h0, 33'he);
    apb(1'b1, `OFF_STRIP0, 32'h8765_4321, 33'h0);
    apb(1'b0, `OFF_STRIP0, 32'h0, 33'h8765_4321);
    for (i = 0; i < 6; i++) begin
      v = i == 0 ? 7'h04 : i == 1 ? 7'h7f : 7'($urandom);
      l = i == 0 ? 10'h12b : i == 1 ? 10'h3ff : 10'($urandom);
      wr(`OFF_BRIGHT, {9'h0, v, 1'b0, v, 1'b0, v});
      wr(`OFF_LONGP, {22'h0, l});
      b = 7'(fit(int'(v), 5, 100));
      lm = 10'(fit(int'(l), 300, 1000));
      check(34'({led_bright, lcd_bright, cl12_led_bright}), 34'({b, b, b}));
      check(34'(long_ms), 34'(lm));
    end
    wr(`OFF_LONGP, 32'h12c);
    third <= 1'b1;
    wr(`OFF_CTRL, 32'h4b);
    ev(0, 4'h2, 1'b0, 10'h000);
    ev(0, 4'h2, 1'b1, 10'h202);
    ev(1, 4'h9, 1'b0, 10'h000);
    ev(1, 4'h9, 1'b1, 10'h109);
    ev(2, 4'h5, 1'b0, 10'h0c5);
    wr(`OFF_CTRL, 32'h40);
    ev(0, 4'h1, 1'b0, 10'h201);
    ev(2, 4'h5, 1'b0, 10'h085);
    {third, cl12} <= 2'b01;
    ev(3, 4'h7, 1'b0, 10'h0c7);
    wr(`OFF_CTRL, 32'h00);
    ev(3, 4'h7, 1'b0, 10'h047);
    ev(4, 4'h0, 1'b0, 10'h000);
    check(34'(edit_current), 34'h0);
    stopped <= 1'b1;
    ev(4, 4'h0, 1'b0, 10'h000);
    check(34'(edit_current), 34'h1);
    surface_model_i.talk();
    repeat (3) @(negedge pclk);
    cl12 <= 1'b0;
    surface_model_i.talk();
    repeat (3) @(negedge pclk);
    check(34'(slate_on), 34'h1);
    act_q.push_back(10'h020);
    surface_model_i.hold(3400);
    act_q.push_back(10'h010);
    surface_model_i.hold(40);
    repeat (6) @(negedge pclk);
    wr(`OFF_CTRL, 32'h10);
    wr(`OFF_GAIN0, 32'h40);
    fad(8'h30, 1'b0, 1'b0, 8'h40);
    fad(8'h40, 1'b0, 1'b0, 8'h40);
    fad(8'h50, 1'b0, 1'b0, 8'h50);
    fad(8'h20, 1'b1, 1'b0, 8'h50);
    fad(8'h22, 1'b1, 1'b1, 8'h22);
    conn <= 1'b1;
    wr(`OFF_CTRL, 32'h00);
    fad(8'h99, 1'b0, 1'b0, 8'h22);
    fad(8'h66, 1'b1, 1'b0, 8'h66);
    wr(`OFF_CTRL, 32'h90);
    wr(`OFF_GAIN0, 32'h10);
    fad(8'h33, 1'b1, 1'b0, 8'h33);
    wr(`OFF_GPIO0, 32'h103);
    wr(`OFF_GPIO0 + 8'h14, 32'h101);
    for (i = 0; i < 2; i++) begin
      func_active[1] <= i[0];
      repeat (3) @(negedge pclk);
      check(34'({gpio_oe[5], gpio_oe[0], gpio_o[5], gpio_o[0]}), 34'({2'b11, i[0], ~i[0]}));
    end
    wr(`OFF_GPIO0 + 8'h0c, 32'h302);
    gpio_i <= 8'h08;
    repeat (8) @(negedge pclk);
    gpio_i <= 8'h12;
    t = 8'h0;
    repeat (8) begin
      @(negedge pclk);
      t = t | gpio_trig;
    end
    check(34'(t), 34'h0a);
    apb(1'b0, `OFF_STATUS, 32'h0, 33'h1_0003);
    check(34'(act_q.size() + rd_q.size()), 34'h0);
    complete_run();
  end
endmodule
`default_nettype wire
